// ---- core/flush_media_regs.vh ----
// register indices, bit positions, codes and reset values of the command block
`ifndef FLUSH_MEDIA_REGS_VH
`define FLUSH_MEDIA_REGS_VH

// register indices on the plain port
`define IDX_ERROR    4'h1
`define IDX_COUNT    4'h2
`define IDX_LOW      4'h3
`define IDX_MID      4'h4
`define IDX_HIGH     4'h5
`define IDX_DEVICE   4'h6
`define IDX_STATUS   4'h7
`define IDX_CONTROL  4'h8
`define IDX_CONFIG   4'h9

// command codes
`define CMD_FLUSH     8'he7
`define CMD_FLUSH_EXT 8'hea
`define CMD_MEDIA     8'hda

// status bits
`define ST_BUSY  7
`define ST_READY 6
`define ST_FAULT 5
`define ST_DRQ   3
`define ST_SENSE 1
`define ST_ERR   0

// error bits
`define ER_WP    6
`define ER_MC    5
`define ER_MCR   3
`define ER_ABORT_FLAG  2
`define ER_NM    1

// device, control and config bits
`define DEV_SEL      4
`define CTL_HOB      7
`define CFG_POSITION 0
`define CFG_NOTIFY   1
`define CFG_MEDIA_OK 2
`define CFG_ABORT28  3

// address limit of the short flush, capability, reset values
`define LBA28_MAX  48'h00000fffffff
`define CAP_48BIT  1'b1
`define RST_STATUS 8'h40
`define RST_CONFIG 8'h0c
`define RST_ZERO   8'h00

`endif

// ---- core/flush_media_cmds.v ----
// device-side cache flush and media status command interpreter
`timescale 1ns/1ns
`default_nettype none
`include "flush_media_regs.vh"

module flush_media_cmds (
  input  wire        clock_i,
  input  wire        reset_i,
  input  wire [3:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output wire [7:0]  rdata_o,
  input  wire        media_present_i,
  input  wire        eject_press_i,
  input  wire        write_protect_i,
  input  wire        flush_done_i,
  input  wire        flush_error_i,
  input  wire        flush_fault_i,
  input  wire        flush_sense_i,
  input  wire [47:0] flush_fail_lba_i,
  output wire        flush_req_o,
  output wire        flush_ext_o,
  output wire [47:0] flush_lba_o,
  output wire        busy_o
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FLUSH = 2'h1;
  localparam [1:0] ST_MEDIA = 2'h2;

  localparam [1:0] K_NONE  = 2'h0;
  localparam [1:0] K_SHORT = 2'h1;
  localparam [1:0] K_LONG  = 2'h2;
  localparam [1:0] K_MEDIA = 2'h3;

  reg [1:0]  state_ff;
  reg [7:0]  error_ff;
  reg [7:0]  feature_ff;
  reg [7:0]  count_ff;
  reg [7:0]  count_prev_ff;
  reg [23:0] lba_ff;
  reg [23:0] lba_prev_ff;
  reg [7:0]  device_ff;
  reg [7:0]  status_ff;
  reg [7:0]  control_ff;
  reg [7:0]  config_ff;
  reg [7:0]  rdata_ff;
  reg        req_ff;
  reg        ext_ff;
  reg [47:0] lba_out_ff;
  reg [47:0] resume28_ff;
  reg [47:0] resume48_ff;
  reg [2:0]  sync1_ff;
  reg [2:0]  sync2_ff;
  reg [2:0]  prev_ff;
  reg        mc_ff;
  reg        mcr_ff;

  // command code to internal kind
  function [1:0] kind_of;
    input [7:0] code;
    begin
      if (code == `CMD_FLUSH)
        kind_of = K_SHORT;
      else if (code == `CMD_FLUSH_EXT)
        kind_of = K_LONG;
      else if (code == `CMD_MEDIA)
        kind_of = K_MEDIA;
      else
        kind_of = K_NONE;
    end
  endfunction

  // synchronised pins: 0 present, 1 eject, 2 protect
  wire       present_s = sync2_ff[0];
  wire       protect_s = sync2_ff[2];
  wire       insert_ev = sync2_ff[0] & ~prev_ff[0];
  wire       eject_ev  = sync2_ff[1] & ~prev_ff[1];

  // command acceptance
  wire [1:0] kind = kind_of(wdata_i);
  wire       ours = device_ff[`DEV_SEL] == config_ff[`CFG_POSITION];
  wire       idle = ~status_ff[`ST_BUSY];
  wire       cmd_wr = wr_i && (addr_i == `IDX_STATUS) && idle
                      && status_ff[`ST_READY] && ours;
  wire       blk_wr = wr_i && idle;

  // media query result
  wire [7:0] media_flags = {1'b0, present_s & protect_s, mc_ff, 1'b0,
                            mcr_ff, 1'b0, ~present_s, 1'b0};

  // failure address forms and error code of a failed flush, short or long
  wire       fail_big = `CAP_48BIT && (flush_fail_lba_i > `LBA28_MAX);
  wire [47:0] fail_next = flush_fail_lba_i + 48'h000000000001;
  wire [7:0] err_flush = (ext_ff | config_ff[`CFG_ABORT28])
                         ? 8'h04 : 8'h00;

  // pin synchronisers and edge history
  always @(posedge clock_i) begin
    if (reset_i) begin
      sync1_ff <= 3'h0;
      sync2_ff <= 3'h0;
      prev_ff  <= 3'h0;
    end else begin
      sync1_ff <= {write_protect_i, eject_press_i, media_present_i};
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // media event latches; a new event beats the clear
  always @(posedge clock_i) begin
    if (reset_i) begin
      mc_ff  <= 1'b0;
      mcr_ff <= 1'b0;
    end else begin
      if (insert_ev)
        mc_ff <= 1'b1;
      else if (state_ff == ST_MEDIA)
        mc_ff <= 1'b0;
      if (eject_ev)
        mcr_ff <= 1'b1;
      else if (state_ff == ST_MEDIA && config_ff[`CFG_NOTIFY])
        mcr_ff <= 1'b0;
    end
  end

  // command block, state machine and back-end handshake
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_ff      <= ST_IDLE;
      error_ff      <= `RST_ZERO;
      feature_ff    <= `RST_ZERO;
      count_ff      <= `RST_ZERO;
      count_prev_ff <= `RST_ZERO;
      lba_ff        <= 24'h000000;
      lba_prev_ff   <= 24'h000000;
      device_ff     <= `RST_ZERO;
      status_ff     <= `RST_STATUS;
      control_ff    <= `RST_ZERO;
      config_ff     <= `RST_CONFIG;
      req_ff        <= 1'b0;
      ext_ff        <= 1'b0;
      lba_out_ff    <= 48'h000000000000;
      resume28_ff   <= 48'h000000000000;
      resume48_ff   <= 48'h000000000000;
    end else begin
      // host writes; command block held while busy
      if (wr_i && addr_i == `IDX_CONTROL) begin
        control_ff <= wdata_i;
      end else if (wr_i && addr_i == `IDX_CONFIG) begin
        config_ff <= wdata_i;
      end else if (blk_wr && addr_i == `IDX_ERROR) begin
        feature_ff <= wdata_i;
      end else if (blk_wr && addr_i == `IDX_COUNT) begin
        count_ff      <= wdata_i;
        count_prev_ff <= count_ff;
      end else if (blk_wr && addr_i == `IDX_LOW) begin
        lba_ff[7:0]      <= wdata_i;
        lba_prev_ff[7:0] <= lba_ff[7:0];
      end else if (blk_wr && addr_i == `IDX_MID) begin
        lba_ff[15:8]      <= wdata_i;
        lba_prev_ff[15:8] <= lba_ff[15:8];
      end else if (blk_wr && addr_i == `IDX_HIGH) begin
        lba_ff[23:16]      <= wdata_i;
        lba_prev_ff[23:16] <= lba_ff[23:16];
      end else if (blk_wr && addr_i == `IDX_DEVICE) begin
        device_ff <= wdata_i;
      end

      case (state_ff)
        ST_IDLE: begin
          if (cmd_wr) begin
            status_ff <= 8'h80;
            error_ff  <= `RST_ZERO;
            case (kind)
              K_SHORT: begin
                state_ff   <= ST_FLUSH;
                req_ff     <= 1'b1;
                ext_ff     <= 1'b0;
                lba_out_ff <= resume28_ff;
              end
              K_LONG: begin
                state_ff   <= ST_FLUSH;
                req_ff     <= 1'b1;
                ext_ff     <= 1'b1;
                lba_out_ff <= resume48_ff;
              end
              default: begin
                state_ff <= ST_MEDIA;
              end
            endcase
            if (kind == K_NONE)
              error_ff <= 8'h04;
          end
        end
        ST_FLUSH: begin
          // busy stays set until the back end ends the flush
          if (flush_error_i) begin
            req_ff   <= 1'b0;
            state_ff <= ST_IDLE;
            error_ff <= err_flush;
            if (ext_ff) begin
              lba_ff      <= flush_fail_lba_i[23:0];
              lba_prev_ff <= flush_fail_lba_i[47:24];
              resume48_ff <= fail_next;
            end else begin
              resume28_ff <= fail_next;
              if (fail_big) begin
                lba_ff         <= 24'hffffff;
                device_ff[3:0] <= 4'hf;
              end else begin
                lba_ff         <= flush_fail_lba_i[23:0];
                device_ff[3:0] <= flush_fail_lba_i[27:24];
              end
            end
            // results land on the same edge that drops busy
            status_ff <= {1'b0, 1'b1, flush_fault_i, 1'b0, 1'b0, 1'b0,
                          ext_ff & flush_sense_i,
                          (|err_flush) & ~(ext_ff & flush_sense_i)};
          end else if (flush_done_i) begin
            req_ff    <= 1'b0;
            state_ff  <= ST_IDLE;
            status_ff <= 8'h40;
            if (ext_ff)
              resume48_ff <= 48'h000000000000;
            else
              resume28_ff <= 48'h000000000000;
          end
        end
        ST_MEDIA: begin
          state_ff <= ST_IDLE;
          if (error_ff[`ER_ABORT_FLAG]) begin
            status_ff <= 8'h41;
          end else if (!config_ff[`CFG_MEDIA_OK]) begin
            error_ff  <= 8'h04;
            status_ff <= 8'h41;
          end else if (!config_ff[`CFG_NOTIFY]) begin
            error_ff  <= 8'h00;
            status_ff <= 8'h40;
          end else begin
            error_ff  <= media_flags;
            status_ff <= {7'h20, |media_flags};
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // registered read data, valid only in the cycle after the strobe
  always @(posedge clock_i) begin
    if (reset_i) begin
      rdata_ff <= 8'h00;
    end else if (!rd_i) begin
      rdata_ff <= 8'h00;
    end else if (addr_i == `IDX_ERROR) begin
      rdata_ff <= error_ff;
    end else if (addr_i == `IDX_COUNT) begin
      rdata_ff <= control_ff[`CTL_HOB] ? count_prev_ff : count_ff;
    end else if (addr_i == `IDX_LOW) begin
      rdata_ff <= control_ff[`CTL_HOB] ? lba_prev_ff[7:0]
                                        : lba_ff[7:0];
    end else if (addr_i == `IDX_MID) begin
      rdata_ff <= control_ff[`CTL_HOB] ? lba_prev_ff[15:8]
                                        : lba_ff[15:8];
    end else if (addr_i == `IDX_HIGH) begin
      rdata_ff <= control_ff[`CTL_HOB] ? lba_prev_ff[23:16]
                                        : lba_ff[23:16];
    end else if (addr_i == `IDX_DEVICE) begin
      rdata_ff <= device_ff;
    end else if (addr_i == `IDX_STATUS) begin
      rdata_ff <= status_ff;
    end else if (addr_i == `IDX_CONTROL) begin
      rdata_ff <= control_ff;
    end else if (addr_i == `IDX_CONFIG) begin
      rdata_ff <= config_ff;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // outputs straight from flops
  assign rdata_o     = rdata_ff;
  assign flush_req_o = req_ff;
  assign flush_ext_o = ext_ff;
  assign flush_lba_o = lba_out_ff;
  assign busy_o      = status_ff[`ST_BUSY];

endmodule // flush_media_cmds
`default_nettype wire

// ---- test/flush_media_checker_assertions.sv ----
// port-level checks of the flush and media command block
`timescale 1ns/1ns
`default_nettype none
`include "flush_media_regs.vh"
module flush_media_checker (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic [3:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        flush_done_i,
  input wire logic        flush_error_i,
  input wire logic [47:0] flush_fail_lba_i,
  input wire logic        flush_req_o,
  input wire logic        flush_ext_o,
  input wire logic [47:0] flush_lba_o,
  input wire logic        busy_o
);
  logic [47:0] res_short_ff;
  logic [47:0] res_long_ff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // expected restart sector per flush kind
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      res_short_ff <= 48'h0;
      res_long_ff  <= 48'h0;
    end else if (flush_req_o && (flush_error_i || flush_done_i)) begin
      if (flush_ext_o)
        res_long_ff <= flush_error_i ? flush_fail_lba_i + 48'h1 : 48'h0;
      else
        res_short_ff <= flush_error_i ? flush_fail_lba_i + 48'h1 : 48'h0;
    end
  end
  a_req_busy: assert property (flush_req_o |-> busy_o)
    else $error("busy low during flush");
  a_req_holds: assert property (flush_req_o && !flush_done_i && !flush_error_i |=> flush_req_o)
    else $error("flush dropped early");
  a_kind_stable: assert property (flush_req_o && $past(flush_req_o) |-> $stable(flush_ext_o))
    else $error("flush kind changed");
  a_done_clears: assert property (flush_req_o && flush_done_i |=> !flush_req_o && !busy_o)
    else $error("busy held after done");
  a_error_clears: assert property (flush_req_o && flush_error_i |=> !flush_req_o && !busy_o)
    else $error("busy held after error");
  a_start_cmd: assert property ($rose(flush_req_o) |-> $past(wr_i) && $past(addr_i) == `IDX_STATUS
    && flush_ext_o == ($past(wdata_i) == `CMD_FLUSH_EXT)
    && ($past(wdata_i) == `CMD_FLUSH || $past(wdata_i) == `CMD_FLUSH_EXT))
    else $error("flush without flush command");
  a_resume_point: assert property ($rose(flush_req_o) |->
    flush_lba_o == (flush_ext_o ? res_long_ff : res_short_ff))
    else $error("wrong restart sector");
  a_status_busy: assert property (rd_i && addr_i == `IDX_STATUS |=> rdata_o[`ST_BUSY] == $past(busy_o))
    else $error("status busy bit differs");
  a_query_short: assert property ($rose(busy_o) && !flush_req_o |-> ##[1:2] !busy_o)
    else $error("non-flush command too long");
  c_done: cover property (flush_req_o && flush_done_i);
  c_long_error: cover property (flush_req_o && flush_error_i && flush_ext_o);
  c_query: cover property ($rose(busy_o) && !flush_req_o);
endmodule // flush_media_checker
bind flush_media_cmds flush_media_checker chk_u (.clock_i, .reset_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .flush_done_i, .flush_error_i, .flush_fail_lba_i, .flush_req_o, .flush_ext_o,
  .flush_lba_o, .busy_o);
`default_nettype wire

// ---- test/flush_backend_model.sv ----
// cache writer model answering flush requests after a set delay
`timescale 1ns/1ns
`default_nettype none
module flush_backend_model (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  input  wire logic        flush_req_i,
  input  wire logic        fail_i,
  input  wire logic        fault_i,
  input  wire logic        sense_i,
  input  wire logic [47:0] lba_i,
  input  wire logic [7:0]  delay_i,
  output wire logic        done_o,
  output wire logic        error_o,
  output wire logic        fault_o,
  output wire logic        sense_o,
  output wire logic [47:0] lba_o
);
  logic [7:0] cnt_ff;
  logic       done_ff;
  logic       error_ff;
  // count while a flush runs, then one done or error pulse
  always_ff @(posedge clock_i) begin
    if (reset_i || !flush_req_i || done_ff || error_ff) begin
      cnt_ff   <= 8'h00;
      done_ff  <= 1'b0;
      error_ff <= 1'b0;
    end else if (cnt_ff == delay_i) begin
      done_ff  <= !fail_i;
      error_ff <= fail_i;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  // sideband lines garbled outside the error pulse
  assign done_o  = done_ff;
  assign error_o = error_ff;
  assign fault_o = error_ff ? fault_i : ~fault_i;
  assign sense_o = error_ff ? sense_i : ~sense_i;
  assign lba_o   = error_ff ? lba_i : ~lba_i;
endmodule // flush_backend_model
`default_nettype wire

// ---- test/flush_media_cmds_bench.sv ----
// self-checking bench of the flush and media command block
`timescale 1ns/1ns
`default_nettype none
`include "flush_media_regs.vh"
module flush_media_cmds_bench;
  logic        clock_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
  logic        media_present_i = 0, eject_press_i = 0, write_protect_i = 0;
  logic        fm = 0, ff = 0, fs = 0;
  logic [3:0]  addr_i = 0;
  logic [7:0]  wdata_i = 0, dly = 0, rv;
  logic [47:0] fl = 0;
  wire         flush_done_i, flush_error_i, flush_fault_i, flush_sense_i;
  wire         flush_req_o, flush_ext_o, busy_o;
  wire  [7:0]  rdata_o;
  wire  [47:0] flush_fail_lba_i, flush_lba_o;
  int          n_errors = 0, check_count = 0;
  flush_media_cmds dut_u (.clock_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .media_present_i, .eject_press_i, .write_protect_i, .flush_done_i, .flush_error_i,
    .flush_fault_i, .flush_sense_i, .flush_fail_lba_i, .flush_req_o, .flush_ext_o,
    .flush_lba_o, .busy_o);
  flush_backend_model be_u (.clock_i, .reset_i, .flush_req_i(flush_req_o), .fail_i(fm),
    .fault_i(ff), .sense_i(fs), .lba_i(fl), .delay_i(dly), .done_o(flush_done_i),
    .error_o(flush_error_i), .fault_o(flush_fault_i), .sense_o(flush_sense_i),
    .lba_o(flush_fail_lba_i));
  // 10 MHz clock
  initial begin
    forever #50 clock_i = ~clock_i;
  end
  task chk(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 0;
  endtask
  task rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock_i);
    rd_i <= 1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 0;
    #1 chk(rdata_o, e);
  endtask
  task idle;
    int i;
    for (i = 0; i < 400 && busy_o !== 1'b0; i++) @(negedge clock_i);
    chk(busy_o, 1'b0);
  endtask
  task flush(input logic [7:0] c, input logic e, input logic [47:0] lba, input logic [47:0] st);
    fm <= e;
    fl <= lba;
    wr(`IDX_STATUS, c);  // issued only while ready is set
    #1 chk(busy_o, 1'b1);
    chk(flush_lba_o, st);
    chk(flush_ext_o, c == `CMD_FLUSH_EXT);
    idle;
  endtask
  task query(input logic [7:0] e, input logic [7:0] s);
    wr(`IDX_STATUS, `CMD_MEDIA);
    idle;
    rchk(`IDX_ERROR, e);
    rchk(`IDX_STATUS, s);
  endtask
  task t_reset;
    rchk(`IDX_STATUS, `RST_STATUS);
    rchk(`IDX_CONFIG, `RST_CONFIG);
    rchk(4'hf, 8'h00);
  endtask
  task t_short;
    dly = 8'd30;
    wr(`IDX_DEVICE, 8'h00);
    flush(`CMD_FLUSH, 0, 48'h0, 48'h0);
    rchk(`IDX_STATUS, 8'h40);
    dly = 8'd0;
    ff = 1;
    flush(`CMD_FLUSH, 1, 48'h9123456, 48'h0);
    rchk(`IDX_ERROR, 8'h04);
    rchk(`IDX_STATUS, 8'h61);
    rchk(`IDX_LOW, 8'h56);
    rchk(`IDX_MID, 8'h34);
    rchk(`IDX_HIGH, 8'h12);
    rchk(`IDX_DEVICE, 8'h09);
    ff = 0;
    flush(`CMD_FLUSH, 1, 48'h123456789abc, 48'h9123457);
    rchk(`IDX_LOW, 8'hff);
    rchk(`IDX_DEVICE, 8'h0f);
    flush(`CMD_FLUSH, 0, 48'h0, 48'h123456789abd);
    rchk(`IDX_STATUS, 8'h40);
  endtask
  task t_long;
    fs = 1;
    flush(`CMD_FLUSH_EXT, 1, 48'habcdef123456, 48'h0);
    rchk(`IDX_ERROR, 8'h04);
    rchk(`IDX_STATUS, 8'h42);
    rchk(`IDX_LOW, 8'h56);
    wr(`IDX_CONTROL, 8'h80);  // upper bytes selected first
    rchk(`IDX_LOW, 8'hef);
    rchk(`IDX_MID, 8'hcd);
    rchk(`IDX_HIGH, 8'hab);
    wr(`IDX_CONTROL, 8'h00);
    fs = 0;
    flush(`CMD_FLUSH_EXT, 1, 48'h1, 48'habcdef123457);
    rchk(`IDX_STATUS, 8'h41);
  endtask
  task t_media;
    wr(`IDX_DEVICE, 8'h10);
    wr(`IDX_STATUS, `CMD_FLUSH);
    #1 chk(busy_o, 1'b0);
    wr(`IDX_DEVICE, 8'h00);
    wr(`IDX_CONFIG, 8'h0e);
    query(8'h02, 8'h41);
    media_present_i <= 1;
    write_protect_i <= 1;
    eject_press_i <= 1;
    repeat (6) @(posedge clock_i);
    eject_press_i <= 0;
    query(8'h68, 8'h41);
    query(8'h40, 8'h41);
    wr(`IDX_CONFIG, 8'h0c);
    query(8'h00, 8'h40);
    write_protect_i <= 0;
    wr(`IDX_CONFIG, 8'h0e);
    query(8'h00, 8'h40);
    wr(`IDX_CONFIG, 8'h0a);
    query(8'h04, 8'h41);
    wr(`IDX_CONFIG, 8'h0e);
    wr(`IDX_STATUS, 8'h00);
    idle;
    rchk(`IDX_ERROR, 8'h04);
    rchk(`IDX_STATUS, 8'h41);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // reset then scenarios
  initial begin
    repeat (5) @(posedge clock_i);
    reset_i <= 0;
    t_reset;
    t_short;
    t_long;
    t_media;
    report_and_stop;
  end
  // hang guard, flushes wait well beyond their delay
  initial begin
    #1000000;
    n_errors++;
    report_and_stop;
  end
endmodule // flush_media_cmds_bench
`default_nettype wire
